// File: dv/cpsc_fet_model.sv
// Behavioural model of the external charge and discharge switches.
`timescale 1ns/10ps
module cpsc_fet_model (
	input  wire logic clock_in,
	input  wire logic charge_gate_in,
	input  wire logic discharge_gate_in,
	output logic      charge_on_out,
	output logic      discharge_on_out
);
	// The switches follow their gates one cycle late, standing in for gate charge time.
	always_ff @(posedge clock_in) begin
		charge_on_out    <= charge_gate_in;
		discharge_on_out <= discharge_gate_in;
	end
endmodule : cpsc_fet_model

// File: dv/cpsc_top_tb.sv
// Self-checking testbench of the cell protection state controller.
`timescale 1ns/10ps
module cpsc_top_tb;
	import cpsc_pkg::*;
	// Short delays keep the run brief; every expectation is derived from them.
	localparam int OVD = 12, COCD = 8, UVD = 10, DOCD = 8, SCD = 6;
	localparam int OVR = 5, UVR = 7, DOCR = 5, COCR = 4;
	// Covers the input synchroniser and filter plus a little slack.
	localparam int MARGIN = 10;
	logic            clock_in;
	logic            rst_n_in;
	logic [N_IN-1:0] stim;
	logic            chg_out;
	logic            dsg_out;
	logic            chg_on;
	logic            dsg_on;
	int              failures = 0;
	int              compares = 0;
	int              cycles = 0;
	// Reference model of the rules on the raw inputs; its outputs are replayed LAT edges late, which is
	// the latency of the three synchroniser stages and the agreement filter.
	localparam int LAT = 4;
	int              m_cst = 0;
	int              m_dst = 0;
	int              m_ov = 0;
	int              m_coc = 0;
	int              m_uv = 0;
	int              m_doc = 0;
	int              m_sc = 0;
	int              m_crel = 0;
	int              m_drel = 0;
	logic [1:0]      m_q [$];

	cpsc_top #(.OV_DET_CYC(OVD), .COC_DET_CYC(COCD), .UV_DET_CYC(UVD), .DOC_DET_CYC(DOCD),
		.SC_DET_CYC(SCD), .OV_REL_CYC(OVR), .UV_REL_CYC(UVR), .DOC_REL_CYC(DOCR),
		.COC_REL_CYC(COCR)) i_dut (
		.clock_in(clock_in), .rst_n_in(rst_n_in),
		.overcharge_det_in(stim[IN_OV_DET]), .overcharge_rel_in(stim[IN_OV_REL]),
		.overdischarge_det_in(stim[IN_UV_DET]), .overdischarge_rel_in(stim[IN_UV_REL]),
		.charge_overcurrent_in(stim[IN_COC]), .discharge_overcurrent_in(stim[IN_DOC]),
		.short_circuit_in(stim[IN_SC]), .load_detect_in(stim[IN_LOAD]),
		.charger_detect_in(stim[IN_CHGR]),
		.charge_switch_drive_out(chg_out), .discharge_switch_drive_out(dsg_out));

	cpsc_fet_model i_fet (.clock_in(clock_in), .charge_gate_in(chg_out), .discharge_gate_in(dsg_out),
		.charge_on_out(chg_on), .discharge_on_out(dsg_on));

	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end

	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// A scenario that stalls still ends the run through the closing report.
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic cmp_level(input string name, input int exp, input logic seen);
		compares++;
		if (seen !== exp[0]) begin
			failures++;
			$display("unexpected %s expected %0d seen %b", name, exp, seen);
		end
	endtask : cmp_level

	task automatic wait_n(input int n);
		repeat (n) @(negedge clock_in);
	endtask : wait_n

	// Model states: 0 normal, 1 voltage fault, 2 current fault.
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			m_cst = 0;
			m_dst = 0;
			m_ov = 0;
			m_coc = 0;
			m_uv = 0;
			m_doc = 0;
			m_sc = 0;
			m_crel = 0;
			m_drel = 0;
			m_q.delete();
		end else begin
			if (m_cst == 0) begin
				m_ov = stim[IN_OV_DET] ? m_ov + 1 : 0;
				m_coc = stim[IN_COC] ? m_coc + 1 : 0;
				m_crel = 0;
				if (m_ov == OVD) m_cst = 1;
				else if (m_coc == COCD) m_cst = 2;
			end else begin
				m_ov = 0;
				m_coc = 0;
				if (m_cst == 1) begin
					m_crel = (stim[IN_OV_REL] || (!stim[IN_OV_DET] && stim[IN_LOAD])) ? m_crel + 1 : 0;
				end else begin
					m_crel = stim[IN_LOAD] ? m_crel + 1 : 0;
				end
				if (m_crel == ((m_cst == 1) ? OVR : COCR)) m_cst = 0;
			end
			if (m_dst == 0) begin
				m_uv = stim[IN_UV_DET] ? m_uv + 1 : 0;
				m_doc = stim[IN_DOC] ? m_doc + 1 : 0;
				m_sc = stim[IN_SC] ? m_sc + 1 : 0;
				m_drel = 0;
				if (m_sc == SCD || m_doc == DOCD) m_dst = 2;
				else if (m_uv == UVD) m_dst = 1;
			end else begin
				m_uv = 0;
				m_doc = 0;
				m_sc = 0;
				if (m_dst == 1) begin
					m_drel = (stim[IN_UV_REL] || (!stim[IN_UV_DET] && stim[IN_CHGR])) ? m_drel + 1 : 0;
				end else begin
					m_drel = !stim[IN_LOAD] ? m_drel + 1 : 0;
				end
				if (m_drel == ((m_dst == 1) ? UVR : DOCR)) m_dst = 0;
			end
			m_q.push_back({m_cst == 0, m_dst == 0});
			if (m_q.size() > LAT + 1) m_q.pop_front();
		end
	end

	// Once the delay line is full the model is held against the design at every cycle.
	always @(negedge clock_in) begin
		if (m_q.size() == LAT + 1) begin
			cmp_level("model charge_switch_drive_out", m_q[0][1], chg_out);
			cmp_level("model discharge_switch_drive_out", m_q[0][0], dsg_out);
		end
	end

	task automatic check_side(input bit discharge_switch_drive, input int exp);
		if (discharge_switch_drive) cmp_level("discharge_switch_drive_out", exp, dsg_out);
		else cmp_level("charge_switch_drive_out", exp, chg_out);
	endtask : check_side

	// The output must hold through the full delay and have fallen shortly after it.
	task automatic trip(input int idx, input int n, input bit discharge_switch_drive);
		stim[idx] = 1'b1;
		wait_n(n);
		check_side(discharge_switch_drive, 1);
		wait_n(MARGIN);
		check_side(discharge_switch_drive, 0);
	endtask : trip

	task automatic release_wait(input int n, input bit discharge_switch_drive);
		wait_n(n);
		check_side(discharge_switch_drive, 0);
		wait_n(MARGIN);
		check_side(discharge_switch_drive, 1);
	endtask : release_wait

	initial begin
		int idx [2];
		int dly [2];
		rst_n_in <= 1'b0;
		stim = '0;
		idx = '{IN_DOC, IN_SC};
		dly = '{DOCD, SCD};
		void'($urandom(63));
		repeat (8) @(negedge clock_in);
		rst_n_in <= 1'b1;
		wait_n(4);
		check_side(0, 1);
		check_side(1, 1);
		stim[IN_OV_DET] = 1'b1;
		wait_n(1 + $urandom % (OVD - 2));
		stim[IN_OV_DET] = 1'b0;
		wait_n(OVD + MARGIN);
		check_side(0, 1);
		trip(IN_OV_DET, OVD, 0);
		stim[IN_OV_DET] = 1'b0;
		stim[IN_OV_REL] = 1'b1;
		release_wait(OVR, 0);
		stim[IN_OV_REL] = 1'b0;
		trip(IN_OV_DET, OVD, 0);
		stim[IN_LOAD] = 1'b1;
		wait_n(OVR + MARGIN);
		check_side(0, 0);
		stim[IN_OV_DET] = 1'b0;
		release_wait(OVR, 0);
		stim[IN_LOAD] = 1'b0;
		trip(IN_COC, COCD, 0);
		stim[IN_COC] = 1'b0;
		stim[IN_LOAD] = 1'b1;
		release_wait(COCR, 0);
		stim[IN_LOAD] = 1'b0;
		trip(IN_UV_DET, UVD, 1);
		stim[IN_UV_DET] = 1'b0;
		stim[IN_UV_REL] = 1'b1;
		release_wait(UVR, 1);
		stim[IN_UV_REL] = 1'b0;
		trip(IN_UV_DET, UVD, 1);
		stim[IN_CHGR] = 1'b1;
		wait_n(UVR + MARGIN);
		check_side(1, 0);
		stim[IN_UV_DET] = 1'b0;
		release_wait(UVR, 1);
		stim[IN_CHGR] = 1'b0;
		for (int i = 0; i < 2; i++) begin
			stim[IN_LOAD] = 1'b1;
			trip(idx[i], dly[i], 1);
			stim[idx[i]] = 1'b0;
			wait_n(DOCR + MARGIN);
			check_side(1, 0);
			stim[IN_LOAD] = 1'b0;
			release_wait(DOCR, 1);
		end
		// A reset in mid-run, taken while the charge side is tripped, must restore both outputs.
		trip(IN_OV_DET, OVD, 0);
		rst_n_in <= 1'b0;
		stim = '0;
		wait_n(2);
		check_side(0, 1);
		rst_n_in <= 1'b1;
		wait_n(LAT + 2);
		check_side(0, 1);
		check_side(1, 1);
		cmp_level("charge_on_out", 1, chg_on);
		cmp_level("discharge_on_out", 1, dsg_on);
		tally_and_finish();
	end
endmodule : cpsc_top_tb

// File: logic/cpsc_pkg.sv
// Constants shared by the cell protection state controller.
package cpsc_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CNT_W  = 27;

	// Detection and release delays in their own units.
	localparam real T_OV_DET_S   = 1.0;
	localparam real T_COC_DET_MS = 16.0;
	localparam real T_UV_DET_MS  = 64.0;
	localparam real T_DOC_DET_MS = 16.0;
	localparam real T_SC_DET_US  = 280.0;
	localparam real T_OV_REL_MS  = 1.0;
	localparam real T_UV_REL_MS  = 5.0;
	localparam real T_DOC_REL_MS = 1.0;
	localparam real T_COC_REL_US = 250.0;

	localparam int unsigned OV_DET_CYC  = int'(T_OV_DET_S * CLK_HZ);
	localparam int unsigned COC_DET_CYC = int'(T_COC_DET_MS * CLK_HZ / 1000.0);
	localparam int unsigned UV_DET_CYC  = int'(T_UV_DET_MS * CLK_HZ / 1000.0);
	localparam int unsigned DOC_DET_CYC = int'(T_DOC_DET_MS * CLK_HZ / 1000.0);
	localparam int unsigned SC_DET_CYC  = int'(T_SC_DET_US * CLK_HZ / 1000000.0);
	localparam int unsigned OV_REL_CYC  = int'(T_OV_REL_MS * CLK_HZ / 1000.0);
	localparam int unsigned UV_REL_CYC  = int'(T_UV_REL_MS * CLK_HZ / 1000.0);
	localparam int unsigned DOC_REL_CYC = int'(T_DOC_REL_MS * CLK_HZ / 1000.0);
	localparam int unsigned COC_REL_CYC = int'(T_COC_REL_US * CLK_HZ / 1000000.0);

	// Bit positions in the comparator input vector.
	localparam int unsigned IN_OV_DET = 0;
	localparam int unsigned IN_OV_REL = 1;
	localparam int unsigned IN_UV_DET = 2;
	localparam int unsigned IN_UV_REL = 3;
	localparam int unsigned IN_COC    = 4;
	localparam int unsigned IN_DOC    = 5;
	localparam int unsigned IN_SC     = 6;
	localparam int unsigned IN_LOAD   = 7;
	localparam int unsigned IN_CHGR   = 8;
	localparam int unsigned N_IN      = 9;

	// Timer slots.
	localparam int unsigned T_OV   = 0;
	localparam int unsigned T_COC  = 1;
	localparam int unsigned T_UV   = 2;
	localparam int unsigned T_DOC  = 3;
	localparam int unsigned T_SC   = 4;
	localparam int unsigned T_CREL = 5;
	localparam int unsigned T_DREL = 6;
	localparam int unsigned N_TMR  = 7;

	typedef enum logic [1:0] {CH_NORMAL, CH_OVERCHG, CH_OVERCUR} cpsc_chg_state_type;
	typedef enum logic [1:0] {DS_NORMAL, DS_OVERDIS, DS_OVERCUR} cpsc_dsg_state_type;
endpackage : cpsc_pkg

// File: logic/cpsc_top.sv
// Protection state controller driving the charge and discharge switch outputs.
// What this block does
// - A persistent overcharge (1.0 s) or charge overcurrent (16 ms) drives the charge switch output low.
// - A persistent overdischarge (64 ms) or discharge overcurrent (16 ms) drives the discharge switch output low.
// - A short circuit persisting for 280 us drives the discharge switch output low.
// - In overcharge, the charge switch returns high once the cell is below the overcharge release level.
// - In overcharge, the charge switch also returns high when the cell is below the detect level and a load is seen.
// - In overdischarge, the discharge switch returns high once the cell is above the release level.
// - In overdischarge, the discharge switch also returns high above the detect level with a charger attached.
// - After a charge overcurrent trip, the charge switch returns high when a load is detected.
// - After a discharge overcurrent or short trip, the discharge switch returns high only once the load is removed.
// - Overcharge release waits 1.0 ms before the charge switch goes high.
// - Overdischarge release waits 5.0 ms before the discharge switch goes high.
// - Discharge overcurrent release waits 1.0 ms after its condition appears.
// - Charge overcurrent release waits 250 us after its condition appears.
`timescale 1ns/10ps
module cpsc_top #(
	parameter int unsigned OV_DET_CYC  = cpsc_pkg::OV_DET_CYC,
	parameter int unsigned COC_DET_CYC = cpsc_pkg::COC_DET_CYC,
	parameter int unsigned UV_DET_CYC  = cpsc_pkg::UV_DET_CYC,
	parameter int unsigned DOC_DET_CYC = cpsc_pkg::DOC_DET_CYC,
	parameter int unsigned SC_DET_CYC  = cpsc_pkg::SC_DET_CYC,
	parameter int unsigned OV_REL_CYC  = cpsc_pkg::OV_REL_CYC,
	parameter int unsigned UV_REL_CYC  = cpsc_pkg::UV_REL_CYC,
	parameter int unsigned DOC_REL_CYC = cpsc_pkg::DOC_REL_CYC,
	parameter int unsigned COC_REL_CYC = cpsc_pkg::COC_REL_CYC
) (
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	input  wire logic overcharge_det_in,
	input  wire logic overcharge_rel_in,
	input  wire logic overdischarge_det_in,
	input  wire logic overdischarge_rel_in,
	input  wire logic charge_overcurrent_in,
	input  wire logic discharge_overcurrent_in,
	input  wire logic short_circuit_in,
	input  wire logic load_detect_in,
	input  wire logic charger_detect_in,
	output logic      charge_switch_drive_out,
	output logic      discharge_switch_drive_out
);
	import cpsc_pkg::*;

	localparam logic [CNT_W-1:0] LIM_OV   = CNT_W'(OV_DET_CYC - 1);
	localparam logic [CNT_W-1:0] LIM_COC  = CNT_W'(COC_DET_CYC - 1);
	localparam logic [CNT_W-1:0] LIM_UV   = CNT_W'(UV_DET_CYC - 1);
	localparam logic [CNT_W-1:0] LIM_DOC  = CNT_W'(DOC_DET_CYC - 1);
	localparam logic [CNT_W-1:0] LIM_SC   = CNT_W'(SC_DET_CYC - 1);
	localparam logic [CNT_W-1:0] LIM_OVR  = CNT_W'(OV_REL_CYC - 1);
	localparam logic [CNT_W-1:0] LIM_UVR  = CNT_W'(UV_REL_CYC - 1);
	localparam logic [CNT_W-1:0] LIM_DOCR = CNT_W'(DOC_REL_CYC - 1);
	localparam logic [CNT_W-1:0] LIM_COCR = CNT_W'(COC_REL_CYC - 1);

	// Reset release synchroniser.
	logic [1:0] rst_sync_r;
	logic       rst_n;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// Comparator inputs are asynchronous; a change is accepted only when stages two and three agree.
	logic [N_IN-1:0] raw;
	logic [N_IN-1:0] sync1_r;
	logic [N_IN-1:0] sync2_r;
	logic [N_IN-1:0] sync3_r;
	logic [N_IN-1:0] filt_r;
	logic [N_IN-1:0] filt_nxt;

	assign raw = {charger_detect_in, load_detect_in, short_circuit_in, discharge_overcurrent_in,
		charge_overcurrent_in, overdischarge_rel_in, overdischarge_det_in, overcharge_rel_in,
		overcharge_det_in};

	always_comb begin
		filt_nxt = (sync2_r & ~(sync2_r ^ sync3_r)) | (filt_r & (sync2_r ^ sync3_r));
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
			filt_r  <= '0;
		end else begin
			sync1_r <= raw;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_r  <= filt_nxt;
		end
	end

	// States, delay timers and output drives.
	cpsc_chg_state_type chg_state_r;
	cpsc_chg_state_type chg_state_nxt;
	cpsc_dsg_state_type dsg_state_r;
	cpsc_dsg_state_type dsg_state_nxt;
	logic [CNT_W-1:0]   cnt_r   [N_TMR];
	logic [CNT_W-1:0]   cnt_nxt [N_TMR];
	logic [CNT_W-1:0]   lim     [N_TMR];
	logic [N_TMR-1:0]   run;
	logic [N_TMR-1:0]   expd;
	logic               chg_out_nxt;
	logic               dsg_out_nxt;

	always_comb begin
		lim[T_OV]   = LIM_OV;
		lim[T_COC]  = LIM_COC;
		lim[T_UV]   = LIM_UV;
		lim[T_DOC]  = LIM_DOC;
		lim[T_SC]   = LIM_SC;
		lim[T_CREL] = (chg_state_r == CH_OVERCHG) ? LIM_OVR : LIM_COCR;
		lim[T_DREL] = (dsg_state_r == DS_OVERDIS) ? LIM_UVR : LIM_DOCR;

		run[T_OV]  = (chg_state_r == CH_NORMAL) && filt_r[IN_OV_DET];
		run[T_COC] = (chg_state_r == CH_NORMAL) && filt_r[IN_COC];
		run[T_UV]  = (dsg_state_r == DS_NORMAL) && filt_r[IN_UV_DET];
		run[T_DOC] = (dsg_state_r == DS_NORMAL) && filt_r[IN_DOC];
		run[T_SC]  = (dsg_state_r == DS_NORMAL) && filt_r[IN_SC];
		run[T_CREL] = ((chg_state_r == CH_OVERCHG) && (filt_r[IN_OV_REL]
			|| (!filt_r[IN_OV_DET] && filt_r[IN_LOAD])))
			|| ((chg_state_r == CH_OVERCUR) && filt_r[IN_LOAD]);
		run[T_DREL] = ((dsg_state_r == DS_OVERDIS) && (filt_r[IN_UV_REL]
			|| (!filt_r[IN_UV_DET] && filt_r[IN_CHGR])))
			|| ((dsg_state_r == DS_OVERCUR) && !filt_r[IN_LOAD]);

		// A dropped condition clears its timer so only a persistent one counts.
		for (int i = 0; i < N_TMR; i++) begin
			expd[i]    = run[i] && (cnt_r[i] == lim[i]);
			cnt_nxt[i] = (run[i] && !expd[i]) ? cnt_r[i] + 1'b1 : '0;
		end

		chg_state_nxt = chg_state_r;
		case (chg_state_r)
			CH_NORMAL: begin
				if (expd[T_OV]) begin
					chg_state_nxt = CH_OVERCHG;
				end else if (expd[T_COC]) begin
					chg_state_nxt = CH_OVERCUR;
				end
			end
			default: begin
				if (expd[T_CREL]) begin
					chg_state_nxt = CH_NORMAL;
				end
			end
		endcase

		dsg_state_nxt = dsg_state_r;
		case (dsg_state_r)
			DS_NORMAL: begin
				if (expd[T_SC] || expd[T_DOC]) begin
					dsg_state_nxt = DS_OVERCUR;
				end else if (expd[T_UV]) begin
					dsg_state_nxt = DS_OVERDIS;
				end
			end
			default: begin
				if (expd[T_DREL]) begin
					dsg_state_nxt = DS_NORMAL;
				end
			end
		endcase

		chg_out_nxt = (chg_state_nxt == CH_NORMAL);
		dsg_out_nxt = (dsg_state_nxt == DS_NORMAL);
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			chg_state_r                <= CH_NORMAL;
			dsg_state_r                <= DS_NORMAL;
			charge_switch_drive_out    <= 1'b1;
			discharge_switch_drive_out <= 1'b1;
			for (int i = 0; i < N_TMR; i++) begin
				cnt_r[i] <= '0;
			end
		end else begin
			chg_state_r                <= chg_state_nxt;
			dsg_state_r                <= dsg_state_nxt;
			charge_switch_drive_out    <= chg_out_nxt;
			discharge_switch_drive_out <= dsg_out_nxt;
			for (int i = 0; i < N_TMR; i++) begin
				cnt_r[i] <= cnt_nxt[i];
			end
		end
	end

	sequence ov_trip_s;
		expd[T_OV] && (chg_state_r == CH_NORMAL);
	endsequence

	sequence chg_low_s;
		!charge_switch_drive_out && (chg_state_r == CH_OVERCHG);
	endsequence

	sequence sc_trip_s;
		expd[T_SC] && (dsg_state_r == DS_NORMAL);
	endsequence

	sequence dsg_oc_low_s;
		!discharge_switch_drive_out && (dsg_state_r == DS_OVERCUR);
	endsequence

	ov_trip_chg_a: assert property (@(posedge clock_in) disable iff (!rst_n)
		ov_trip_s |=> chg_low_s)
		else $error("overcharge expiry did not drop the charge switch");

	chg_fall_cause_a: assert property (@(posedge clock_in) disable iff (!rst_n)
		$fell(charge_switch_drive_out) |-> $past(expd[T_OV]) || $past(expd[T_COC]))
		else $error("charge switch fell without a detection expiry");

	dsg_fall_cause_a: assert property (@(posedge clock_in) disable iff (!rst_n)
		$fell(discharge_switch_drive_out) |-> $past(expd[T_UV]) || $past(expd[T_DOC]) || $past(expd[T_SC]))
		else $error("discharge switch fell without a detection expiry");

	sc_trip_dsg_a: assert property (@(posedge clock_in) disable iff (!rst_n)
		sc_trip_s |=> dsg_oc_low_s)
		else $error("short circuit expiry did not drop the discharge switch");

	chg_rise_cause_a: assert property (@(posedge clock_in) disable iff (!rst_n)
		$rose(charge_switch_drive_out) |-> $past(expd[T_CREL]) && $past(run[T_CREL]))
		else $error("charge switch rose without a completed release delay");

	dsg_load_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n)
		(dsg_state_r == DS_OVERCUR) && filt_r[IN_LOAD] |=> !discharge_switch_drive_out)
		else $error("discharge switch released while load still present");

	coc_load_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n)
		(chg_state_r == CH_OVERCUR) && !filt_r[IN_LOAD] |=> !charge_switch_drive_out)
		else $error("charge switch released with no load present");

	timer_restart_a: assert property (@(posedge clock_in) disable iff (!rst_n)
		!run[T_SC] |=> (cnt_r[T_SC] == '0))
		else $error("short circuit timer not restarted");

	dsg_rel_wait_a: assert property (@(posedge clock_in) disable iff (!rst_n)
		$rose(discharge_switch_drive_out) |-> $past(cnt_r[T_DREL]) == $past(lim[T_DREL]))
		else $error("discharge switch rose before its release delay");

	reset_high_a: assert property (@(posedge clock_in)
		!rst_n |=> charge_switch_drive_out && discharge_switch_drive_out)
		else $error("switch outputs not high after reset");
endmodule : cpsc_top
